//--- logic/sinc_regs.svh
// Purpose: Register offsets, field positions, reset values and counts for the decimator.
// Assumes: Byte addresses on a 32-bit classic Wishbone slave.
// Notes: Definitions only.
`ifndef SINC_REGS_SVH
`define SINC_REGS_SVH

// Register byte offsets
`define REG_SETUP_OFS 8'h00
`define REG_OFFSET_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_DATA_OFS 8'h0c

// Setup register layout
`define SETUP_W 12
`define SETUP_RST 12'h001
`define SETUP_LO_W 8

// Offset DAC register layout
`define DAC_MAG_W 3
`define DAC_SIGN_BIT 3
`define DAC_RST 4'h0

// Status register bit positions
`define STAT_VALID_BIT 0
`define STAT_SETTLE_BIT 1
`define STAT_PER_LSB 2
`define STAT_HOLD_BIT 4

// Result word and arithmetic widths
`define RESULT_W 18
`define ACC_W 32
`define DEC_W 10

// Decimation factors, clock select 1 then 0, indexed by rate select
`define DEC_C1_FS0 10'h180
`define DEC_C1_FS1 10'h140
`define DEC_C1_FS2 10'h040
`define DEC_C1_FS3 10'h020
`define DEC_C0_FS0 10'h190
`define DEC_C0_FS1 10'h140
`define DEC_C0_FS2 10'h040
`define DEC_C0_FS3 10'h020

// Internal clock ticks per modulator sample at the lowest modulator rate
`define MOD_DIV_DEF 8'h80

// Output periods needed before a result is valid
`define SETTLE_SINC1 2'h1
`define SETTLE_SINC3 2'h3

`endif

//--- logic/sinc_pkg.sv
// Purpose: Types shared by the decimator and its control logic.
// Assumes: Constants come from sinc_regs.svh.
// Notes: Setup struct packs low bit first as clk_sel.
package sinc_pkg;

   // Global setup register image
   typedef struct packed {
      logic bipolar;
      logic full_power_down;
      logic standby_ctl;
      logic conversion_hold;
      logic filter_bypass;
      logic fast;
      logic rate_sel_hi;
      logic rate_sel_lo;
      logic mod_freq_sel_hi;
      logic mod_freq_sel_lo;
      logic prescale_div2_en;
      logic clk_sel;
   } setup_t;

   // Coarse offset code, sign plus magnitude
   typedef struct packed {
      logic sign;
      logic [2:0] mag;
   } dac_code_t;

   // Analog control outputs
   typedef struct packed {
      logic analog_pd;
      logic osc_drive_en;
      logic dac_connect;
      logic dac_sign;
      logic [2:0] dac_mag;
      logic [4:0] offset_twelfths;
   } analog_ctl_t;

   // Filter sequencing
   typedef enum logic [1:0] {
      FLT_OFF = 2'b00,
      FLT_RUN = 2'b01,
      FLT_DIVIDE = 2'b10
   } flt_state_t;

endpackage

//--- logic/sinc_divider.sv
// Purpose: Sequential restoring divider used for the 1/N normalisation.
// Assumes: Start only while idle; one quotient bit per clock.
// Notes: Quotient saturates to the result width.
`timescale 1ns/1ps
`default_nettype none
`include "sinc_regs.svh"
module sinc_divider #(
   parameter int DW = 50,
   parameter int VW = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Request
   input wire logic start,
   input wire logic [DW-1:0] dividend,
   input wire logic [VW-1:0] divisor,
   // Answer
   output logic busy,
   output logic done,
   output logic [`RESULT_W-1:0] quotient
);
   logic [DW-1:0] num_q;
   logic [DW-1:0] quo_q;
   logic [VW:0] rem_q;
   logic [VW-1:0] den_q;
   logic [6:0] cnt_q;
   logic run_q;
   logic done_q;
   logic [`RESULT_W-1:0] quot_q;
   logic [VW:0] trial;
   logic [VW:0] shifted;

   // One shift-subtract step
   assign shifted = {rem_q[VW-1:0], num_q[DW-1]};
   assign trial = shifted - {1'b0, den_q};

   // Iteration state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         num_q <= '0;
         quo_q <= '0;
         rem_q <= '0;
         den_q <= '0;
         cnt_q <= 7'h00;
         run_q <= 1'b0;
      end else if (start && !run_q) begin
         num_q <= dividend;
         quo_q <= '0;
         rem_q <= '0;
         den_q <= divisor;
         cnt_q <= 7'(DW);
         run_q <= 1'b1;
      end else if (run_q) begin
         num_q <= {num_q[DW-2:0], 1'b0};
         rem_q <= trial[VW] ? shifted : trial;
         quo_q <= {quo_q[DW-2:0], ~trial[VW]};
         cnt_q <= cnt_q - 7'h01;
         if (cnt_q == 7'h01) begin
            run_q <= 1'b0;
         end
      end
   end

   // Saturated result, registered with its done pulse
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         quot_q <= '0;
      end else begin
         done_q <= run_q && (cnt_q == 7'h01);
         if (run_q && (cnt_q == 7'h01)) begin
            if (|{quo_q[DW-2:`RESULT_W-1]}) begin
               quot_q <= '1;
            end else begin
               quot_q <= {quo_q[`RESULT_W-2:0], ~trial[VW]};
            end
         end
      end
   end

   assign busy = run_q;
   assign done = done_q;
   assign quotient = quot_q;
endmodule
`default_nettype wire

//--- logic/sinc_decimator_clock_ctrl.sv
// Purpose: Sigma-delta back end: SINC3/SINC1 decimation, clocking, power and offset control.
// Assumes: 100 MHz system clock; master clock and modulator bit arrive as pins.
// Notes: Registers on classic Wishbone, one-cycle registered ack.
`timescale 1ns/1ps
`default_nettype none
`include "sinc_regs.svh"
module sinc_decimator_clock_ctrl #(
   parameter logic [7:0] MOD_DIV = `MOD_DIV_DEF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Oscillator and modulator pins
   input wire logic osc_in_pin,
   output logic osc_out_pin,
   input wire logic mod_bit_in,
   // Serial output path
   input wire logic ser_data_in,
   output logic ser_data_out,
   output logic result_valid_flag,
   // Analog side controls
   output sinc_pkg::analog_ctl_t analog_ctl,
   output logic mod_sample_strobe
);
   import sinc_pkg::*;

   localparam int DIVW = `ACC_W + `RESULT_W;

   setup_t setup_q;
   dac_code_t dac_q;
   analog_ctl_t actl_q;
   flt_state_t state_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic [2:0] osc_sync_q;
   logic [2:0] mod_sync_q;
   logic osc_lvl_q;
   logic mod_lvl_q;
   logic pre_q;
   logic osc_out_q;
   logic sdo_q;
   logic [7:0] mod_cnt_q;
   logic [`DEC_W-1:0] dec_cnt_q;
   logic [`ACC_W-1:0] int1_q, int2_q, int3_q;
   logic [`ACC_W-1:0] dly1_q, dly2_q, dly3_q;
   logic [`ACC_W-1:0] comb_in, comb1, comb2, comb3, sample;
   logic [1:0] per_q;
   logic valid_q;
   logic [6:0] key_q;
   logic [6:0] key_now;
   logic osc_rise, int_tick, mod_tick, out_tick;
   logic running, restart;
   logic [`DEC_W-1:0] dec_n;
   logic [`ACC_W-1:0] div_den;
   logic [7:0] mod_limit;
   logic [1:0] need;
   logic div_busy, div_done;
   logic [`RESULT_W-1:0] div_quot;
   logic [`RESULT_W-1:0] result_q;
   logic bus_req, wr_setup, wr_dac, rd_data;

   // Decimation factor from clock select and rate select
   function automatic logic [`DEC_W-1:0] dec_factor(input logic csel, input logic [1:0] fs);
      logic [`DEC_W-1:0] n;
      n = `DEC_C1_FS0;
      case ({csel, fs})
         3'h4: n = `DEC_C1_FS0;
         3'h5: n = `DEC_C1_FS1;
         3'h6: n = `DEC_C1_FS2;
         3'h7: n = `DEC_C1_FS3;
         3'h0: n = `DEC_C0_FS0;
         3'h1: n = `DEC_C0_FS1;
         3'h2: n = `DEC_C0_FS2;
         default: n = `DEC_C0_FS3;
      endcase
      return n;
   endfunction

   // Synchronised level follows once the second and third stages agree
   function automatic logic agreed(input logic [2:0] s, input logic prev);
      return (s[1] == s[2]) ? s[2] : prev;
   endfunction

   // Pin synchronisers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         osc_sync_q <= 3'h0;
         mod_sync_q <= 3'h0;
         osc_lvl_q <= 1'b0;
         mod_lvl_q <= 1'b0;
      end else begin
         osc_sync_q <= {osc_sync_q[1:0], osc_in_pin};
         mod_sync_q <= {mod_sync_q[1:0], mod_bit_in};
         osc_lvl_q <= agreed(osc_sync_q, osc_lvl_q);
         mod_lvl_q <= agreed(mod_sync_q, mod_lvl_q);
      end
   end

   assign osc_rise = osc_sync_q[1] & osc_sync_q[2] & ~osc_lvl_q;

   // Prescaler: every second master edge when enabled, giving an even duty
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 1'b0;
      end else if (!setup_q.prescale_div2_en || setup_q.full_power_down) begin
         pre_q <= 1'b0;
      end else if (osc_rise) begin
         pre_q <= ~pre_q;
      end
   end

   // Oscillator stops entirely in full power-down
   assign int_tick = osc_rise & ~setup_q.full_power_down
                     & (~setup_q.prescale_div2_en | pre_q);

   // Modulator rate: faster for higher modulator-frequency codes
   assign mod_limit = MOD_DIV >> {setup_q.mod_freq_sel_hi, setup_q.mod_freq_sel_lo};
   assign running = ~setup_q.standby_ctl & ~setup_q.full_power_down
                    & ~setup_q.conversion_hold;

   // Configuration key; any change restarts the filter
   assign key_now = {setup_q.clk_sel, setup_q.prescale_div2_en, setup_q.mod_freq_sel_hi,
                     setup_q.mod_freq_sel_lo, setup_q.rate_sel_hi, setup_q.rate_sel_lo,
                     setup_q.fast};
   assign restart = (key_now != key_q) || !running;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         key_q <= 7'h40;
      end else begin
         key_q <= key_now;
      end
   end

   // Modulator sample divider
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mod_cnt_q <= 8'h00;
      end else if (restart) begin
         mod_cnt_q <= 8'h00;
      end else if (int_tick) begin
         mod_cnt_q <= (mod_cnt_q >= mod_limit - 8'h01) ? 8'h00 : mod_cnt_q + 8'h01;
      end
   end

   assign mod_tick = int_tick && !restart && (mod_cnt_q >= mod_limit - 8'h01);
   assign mod_sample_strobe = mod_tick;

   // Decimation counter: one output word every N modulator samples
   assign dec_n = dec_factor(setup_q.clk_sel, {setup_q.rate_sel_hi, setup_q.rate_sel_lo});
   assign out_tick = mod_tick && (dec_cnt_q == dec_n - 10'h001);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dec_cnt_q <= '0;
      end else if (restart) begin
         dec_cnt_q <= '0;
      end else if (mod_tick) begin
         dec_cnt_q <= out_tick ? '0 : dec_cnt_q + 10'h001;
      end
   end

   // Integrators at modulator rate; wrap-around is harmless for the combs
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         int1_q <= '0;
         int2_q <= '0;
         int3_q <= '0;
      end else if (restart) begin
         int1_q <= '0;
         int2_q <= '0;
         int3_q <= '0;
      end else if (mod_tick) begin
         int1_q <= int1_q + {31'h0, mod_lvl_q};
         int2_q <= int2_q + int1_q;
         int3_q <= int3_q + int2_q;
      end
   end

   // Combs at output rate; first order uses a single stage
   // Updated integrator values, so the sample at the tick itself is not lost
   assign comb_in = setup_q.fast ? int1_q + {31'h0, mod_lvl_q} : int3_q + int2_q;
   assign comb1 = comb_in - dly1_q;
   assign comb2 = comb1 - dly2_q;
   assign comb3 = comb2 - dly3_q;
   assign sample = setup_q.fast ? comb1 : comb3;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dly1_q <= '0;
         dly2_q <= '0;
         dly3_q <= '0;
      end else if (restart) begin
         dly1_q <= '0;
         dly2_q <= '0;
         dly3_q <= '0;
      end else if (out_tick) begin
         dly1_q <= comb_in;
         dly2_q <= comb1;
         dly3_q <= comb2;
      end
   end

   // Output periods counted since restart, saturating
   assign need = setup_q.fast ? `SETTLE_SINC1 : `SETTLE_SINC3;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         per_q <= 2'h0;
      end else if (restart) begin
         per_q <= 2'h0;
      end else if (out_tick && per_q != 2'h3) begin
         per_q <= per_q + 2'h1;
      end
   end

   // Normalisation: 1/N per stage, so N cubed for third order
   assign div_den = setup_q.fast ? {22'h0, dec_n}
                                 : `ACC_W'({22'h0, dec_n} * {22'h0, dec_n} * {22'h0, dec_n});

   // Filter sequencing; a restart abandons a division in flight
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= FLT_OFF;
      end else begin
         case (state_q)
            FLT_OFF: begin
               if (!restart) begin
                  state_q <= FLT_RUN;
               end
            end
            FLT_RUN: begin
               if (restart) begin
                  state_q <= FLT_OFF;
               end else if (out_tick && (per_q >= need - 2'h1)) begin
                  state_q <= FLT_DIVIDE;
               end
            end
            FLT_DIVIDE: begin
               if (restart) begin
                  state_q <= FLT_OFF;
               end else if (div_done) begin
                  state_q <= FLT_RUN;
               end
            end
            default: state_q <= FLT_OFF;
         endcase
      end
   end

   sinc_divider #(
      .DW(DIVW),
      .VW(`ACC_W)
   ) u_div (
      .clock(clock),
      .rst_n(rst_n),
      .start(state_q == FLT_RUN && !restart && out_tick && (per_q >= need - 2'h1)),
      .dividend({sample, {`RESULT_W{1'b0}}}),
      .divisor(div_den),
      .busy(div_busy),
      .done(div_done),
      .quotient(div_quot)
   );

   // Result word and data-ready flag; new data wins over a read clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= '0;
         valid_q <= 1'b0;
      end else if (restart) begin
         valid_q <= 1'b0;
      end else if (state_q == FLT_DIVIDE && div_done) begin
         result_q <= div_quot;
         valid_q <= 1'b1;
      end else if (rd_data) begin
         valid_q <= 1'b0;
      end
   end

   assign result_valid_flag = valid_q;

   // Serial output: raw modulator bits in bypass, else the shift register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sdo_q <= 1'b0;
         osc_out_q <= 1'b0;
      end else begin
         sdo_q <= setup_q.filter_bypass ? mod_lvl_q : ser_data_in;
         osc_out_q <= setup_q.full_power_down ? 1'b0 : ~osc_lvl_q;
      end
   end

   assign ser_data_out = sdo_q;
   assign osc_out_pin = osc_out_q;

   // Analog controls: offset in twelfths of range, signed
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         actl_q <= '0;
      end else begin
         actl_q.analog_pd <= setup_q.standby_ctl | setup_q.full_power_down;
         actl_q.osc_drive_en <= ~setup_q.full_power_down;
         actl_q.dac_connect <= |dac_q.mag;
         actl_q.dac_sign <= dac_q.sign & (|dac_q.mag);
         actl_q.dac_mag <= dac_q.mag;
         if (dac_q.sign) begin
            actl_q.offset_twelfths <= 5'h00 - (setup_q.bipolar ? {2'h0, dac_q.mag}
                                                               : {1'b0, dac_q.mag, 1'b0});
         end else begin
            actl_q.offset_twelfths <= setup_q.bipolar ? {2'h0, dac_q.mag}
                                                      : {1'b0, dac_q.mag, 1'b0};
         end
      end
   end

   assign analog_ctl = actl_q;

   // Bus decode; ack one cycle after the request, dropped the next
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_setup = bus_req & wb_we_i & (wb_adr_i == `REG_SETUP_OFS);
   assign wr_dac = bus_req & wb_we_i & (wb_adr_i == `REG_OFFSET_OFS);
   assign rd_data = bus_req & ~wb_we_i & (wb_adr_i == `REG_DATA_OFS);

   // Writable registers with byte lanes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         setup_q <= `SETUP_RST;
         dac_q <= `DAC_RST;
      end else begin
         if (wr_setup && wb_sel_i[0]) begin
            setup_q[`SETUP_LO_W-1:0] <= wb_dat_i[`SETUP_LO_W-1:0];
         end
         if (wr_setup && wb_sel_i[1]) begin
            setup_q[`SETUP_W-1:`SETUP_LO_W] <= wb_dat_i[`SETUP_W-1:`SETUP_LO_W];
         end
         if (wr_dac && wb_sel_i[0]) begin
            dac_q <= wb_dat_i[`DAC_SIGN_BIT:0];
         end
      end
   end

   // Read data and ack; unmapped addresses ack with zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         rdat_q <= 32'h0000_0000;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               `REG_SETUP_OFS: rdat_q[`SETUP_W-1:0] <= setup_q;
               `REG_OFFSET_OFS: rdat_q[`DAC_SIGN_BIT:0] <= dac_q;
               `REG_STATUS_OFS: begin
                  rdat_q[`STAT_VALID_BIT] <= valid_q;
                  rdat_q[`STAT_SETTLE_BIT] <= (state_q != FLT_OFF) && !valid_q;
                  rdat_q[`STAT_PER_LSB+1:`STAT_PER_LSB] <= per_q;
                  rdat_q[`STAT_HOLD_BIT] <= setup_q.conversion_hold | div_busy;
               end
               `REG_DATA_OFS: rdat_q[`RESULT_W-1:0] <= result_q;
               default: rdat_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
endmodule
`default_nettype wire

//--- testbench/sinc_mod_model.sv
// Purpose: Crystal, modulator and serial register stand-in.
// Assumes: Crystal half period of six system cycles.
// Notes: mode 0 zeros, 1 ones, 2 slow square wave.
`timescale 1ns/1ps
`default_nettype none
module sinc_mod_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Controls
   input wire logic osc_en,
   input wire logic [1:0] mode,
   // Pins into the device
   output logic osc_in_pin,
   output logic mod_bit_in,
   output logic ser_data_in
);
   logic [7:0] cnt_q;
   logic [2:0] half_q;
   // Crystal stalls while its drive is off, like a real resonator
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         half_q <= 3'h0;
         osc_in_pin <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         if (osc_en) begin
            half_q <= (half_q == 3'h5) ? 3'h0 : half_q + 3'h1;
            if (half_q == 3'h5) osc_in_pin <= ~osc_in_pin;
         end
      end
   end
   // One-bit stream, level or square wave slow against the sync stages
   assign mod_bit_in = mode[1] ? cnt_q[5] : mode[0];
   assign ser_data_in = cnt_q[2];
endmodule
`default_nettype wire

//--- testbench/sinc_decimator_clock_ctrl_monitor.sv
// Purpose: Port checks for the decimator.
// Assumes: One clock, async active-low reset.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module sinc_decimator_clock_ctrl_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins and controls
   input wire logic osc_out_pin,
   input wire logic result_valid_flag,
   input wire sinc_pkg::analog_ctl_t analog_ctl,
   input wire logic mod_sample_strobe
);
   import sinc_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [4:0] off_abs;
   // Offset magnitude, so one check covers both signs
   assign off_abs = analog_ctl.offset_twelfths[4] ? -analog_ctl.offset_twelfths
      : analog_ctl.offset_twelfths;
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence ans_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   bus_answer_a: assert property (req_s |=> ans_s)
      else $error("ack not a single pulse after request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero while idle");
   dac_off_a: assert property (analog_ctl.dac_mag == 3'h0 |->
      !analog_ctl.dac_connect && !analog_ctl.dac_sign && analog_ctl.offset_twelfths == 5'h0)
      else $error("zero offset code still connected");
   dac_step_a: assert property (analog_ctl.dac_connect |->
      analog_ctl.dac_sign == analog_ctl.offset_twelfths[4] && (off_abs == {2'h0,
      analog_ctl.dac_mag} || off_abs == {1'h0, analog_ctl.dac_mag, 1'h0}))
      else $error("offset step size wrong");
   pd_analog_a: assert property (!analog_ctl.osc_drive_en && $past(rst_n) |->
      analog_ctl.analog_pd)
      else $error("power-down left analog on");
   pd_osc_out_pin_a: assert property (!analog_ctl.osc_drive_en [*2] |-> !osc_out_pin)
      else $error("crystal drive active in power-down");
   standby_ctl_valid_a: assert property (analog_ctl.analog_pd |-> !result_valid_flag)
      else $error("data ready while powered down");
   strobe_pulse_a: assert property (mod_sample_strobe |=> !mod_sample_strobe)
      else $error("sample strobe longer than one cycle");
endmodule
bind sinc_decimator_clock_ctrl sinc_decimator_clock_ctrl_monitor mon_u (
   .clock(clock),
   .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .osc_out_pin(osc_out_pin),
   .result_valid_flag(result_valid_flag),
   .analog_ctl(analog_ctl),
   .mod_sample_strobe(mod_sample_strobe)
);
`default_nettype wire

//--- testbench/sinc_decimator_clock_ctrl_tb.sv
// Purpose: Self-checking bench for the decimator.
// Assumes: MOD_DIV of 2 and modulator select 1, one sample per 12 cycles, 24 with the prescaler.
// Notes: Expected delays carry slack for pin synchronisers and division.
`timescale 1ns/1ps
`default_nettype none
module sinc_decimator_clock_ctrl_tb;
   import sinc_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic [1:0] mode = 2'h0;
   logic ack, osc_in, osc_out, mbit, sdi, sdo, valid, strobe;
   analog_ctl_t actl;
   int failures = 0, n_compared = 0;
   // 100 MHz clock
   always #5 clock = ~clock;
   sinc_decimator_clock_ctrl #(.MOD_DIV(8'h02)) dut_u (.clock(clock), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .osc_in_pin(osc_in),
      .osc_out_pin(osc_out), .mod_bit_in(mbit), .ser_data_in(sdi), .ser_data_out(sdo),
      .result_valid_flag(valid), .analog_ctl(actl), .mod_sample_strobe(strobe));
   sinc_mod_model far_u (.clock(clock), .rst_n(rst_n), .osc_en(actl.osc_drive_en),
      .mode(mode), .osc_in_pin(osc_in), .mod_bit_in(mbit), .ser_data_in(sdi));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= d;
      sel <= s;
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      wb(1'b0, 8'h00, 32'h0, 4'hf, q);
      chk("setup_reset", 32'h001, q);
      wb(1'b0, 8'h04, 32'h0, 4'hf, q);
      chk("offset_reset", 32'h0, q);
      wb(1'b1, 8'h00, 32'h800, 4'h2, q);
      wb(1'b1, 8'h00, 32'hf34, 4'h1, q);
      wb(1'b1, 8'h10, 32'hffff, 4'hf, q);
      wb(1'b0, 8'h10, 32'h0, 4'hf, q);
      chk("unmapped", 32'h0, q);
      wb(1'b0, 8'h00, 32'h0, 4'hf, q);
      chk("setup_lanes", 32'h834, q);
      wb(1'b1, 8'h00, 32'h001, 4'hf, q);
      $display("regs done");
   endtask
   // Every code in both polarity modes
   task automatic t_dac();
      logic [31:0] q;
      logic [4:0] o;
      for (int i = 0; i < 32; i++) begin
         wb(1'b1, 8'h00, {20'h0, i[4], 11'h001}, 4'hf, q);
         wb(1'b1, 8'h04, {28'h0, i[3:0]}, 4'hf, q);
         o = i[2:0] * (i[4] ? 5'h01 : 5'h02);
         if (i[3]) o = -o;
         chk("dac", {i[2:0] != 3'h0, i[3] && i[2:0] != 3'h0, i[2:0], o},
            {actl.dac_connect, actl.dac_sign, actl.dac_mag, actl.offset_twelfths});
      end
      wb(1'b1, 8'h00, 32'h001, 4'hf, q);
      $display("dac done");
   endtask
   task automatic t_bypass();
      logic [31:0] q;
      logic last, prev;
      int st;
      st = 0;
      mode <= 2'h2;
      wb(1'b1, 8'h00, 32'h081, 4'hf, q);
      for (int i = 0; i < 300; i++) begin
         @(posedge clock);
         st = (mbit === last) ? st + 1 : 0;
         last = mbit;
         if (st > 8) chk("bypass", mbit, sdo);
      end
      wb(1'b1, 8'h00, 32'h001, 4'hf, q);
      for (int i = 0; i < 50; i++) begin
         @(posedge clock);
         if (i > 2) chk("serial", prev, sdo);
         prev = sdi;
      end
      $display("bypass done");
   endtask
   // Restart, first result after k periods, data, then one period per word
   task automatic conv(input logic [11:0] s, input int k, input int n, input logic [17:0] e);
      int p, t;
      logic [31:0] q;
      p = n * 12 * (s[1] ? 2 : 1);
      wb(1'b1, 8'h00, {20'h0, s}, 4'hf, q);
      chk("flag_drop", 32'h0, valid);
      t = 0;
      while (valid !== 1'b1 && t < k * p + 400) begin
         @(posedge clock);
         t++;
      end
      chk("settle", 1, t > k * p - 30 && t < k * p + 150);
      wb(1'b0, 8'h0c, 32'h0, 4'hf, q);
      chk("data", e, q);
      chk("flag_clear", 32'h0, valid);
      t = 0;
      while (valid !== 1'b1 && t < p + 100) begin
         @(posedge clock);
         t++;
      end
      chk("period", 1, t > p - 40 && t < p + 40);
      $display("conv %h done", s);
   endtask
   task automatic t_power();
      logic [31:0] q;
      wb(1'b1, 8'h00, 32'h375, 4'hf, q);
      wb(1'b1, 8'h00, 32'h275, 4'hf, q);
      repeat (800) @(posedge clock);
      chk("hold_standby_ctl", 3'b011, {valid, actl.analog_pd, actl.osc_drive_en});
      wb(1'b1, 8'h00, 32'h175, 4'hf, q);
      repeat (900) @(posedge clock);
      wb(1'b0, 8'h08, 32'h0, 4'hf, q);
      chk("hold", 2'b01, {valid, q[4]});
      wb(1'b1, 8'h00, 32'h401, 4'hf, q);
      repeat (20) @(posedge clock);
      chk("fpd", 3'b100, {actl.analog_pd, actl.osc_drive_en, osc_out});
      wb(1'b1, 8'h00, 32'h075, 4'hf, q);
      repeat (100) @(posedge clock);
      do_reset();
      wb(1'b0, 8'h00, 32'h0, 4'hf, q);
      chk("after_reset", 32'h001, q);
      $display("power done");
   endtask
   task automatic print_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      do_reset();
      t_regs();
      t_dac();
      t_bypass();
      mode <= 2'h1;
      repeat (10) @(posedge clock);
      conv(12'h075, 1, 32, 18'h3ffff);
      conv(12'h035, 3, 32, 18'h3ffff);
      conv(12'h005, 3, 384, 18'h3ffff);
      mode <= 2'h0;
      repeat (10) @(posedge clock);
      conv(12'h025, 3, 64, 18'h0);
      conv(12'h077, 1, 32, 18'h0);
      conv(12'h044, 1, 400, 18'h0);
      t_power();
      print_verdict();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (100000) @(posedge clock);
      failures++;
      print_verdict();
   end
endmodule
`default_nettype wire
